// ---- verilog/pcst_pkg.sv ----
// Purpose: Constants and types for the printer configuration and self-test block
// Assumes: 40 MHz system clock, Wishbone classic register access
// Notes: Register byte addresses are word aligned
`default_nettype none
package pcst_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_SERIAL_CFG = 4'h0;
    localparam logic [3:0] ADDR_MECH_CFG = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    // Control register bit positions
    localparam int CTL_ROLL_AUTO = 0;
    localparam int CTL_FAN_AUTO = 1;
    localparam int CTL_FEED_LEN_LSB = 8;
    // Reset values
    localparam logic [7:0] FEED_LEN_RST = 8'h00;
    // Baud rates in bits per second
    localparam logic [15:0] BAUD_19200 = 16'h4b00;
    localparam logic [15:0] BAUD_9600 = 16'h2580;
    localparam logic [15:0] BAUD_4800 = 16'h12c0;
    localparam logic [15:0] BAUD_1200 = 16'h04b0;
    // Receive buffer sizes in bytes
    localparam logic [12:0] RXBUF_LARGE = 13'h1000;
    localparam logic [12:0] RXBUF_SMALL = 13'h002d;
    // Feed step unit: one step enable per this many clocks (1 ms at 40 MHz)
    localparam int CLK_HZ = 40000000;
    localparam int FEED_STEP_US = 1000;
    localparam int FEED_STEP_CYC = CLK_HZ / 1000000 * FEED_STEP_US;
    // Step count at which a self-test ticket ends; the ticket runs this many feed steps plus one
    localparam logic [7:0] TEST_TICKET_STEPS = 8'h40;
    // ASCII digit base for the width character
    localparam logic [7:0] ASCII_ZERO = 8'h30;

    typedef enum logic [2:0] {
        PCST_SAMPLE,
        PCST_IDLE,
        PCST_TEST_PRINT,
        PCST_TEST_CUT,
        PCST_ROLL_FEED,
        PCST_FAN_FEED,
        PCST_MANUAL_FEED
    } pcst_state_t;
endpackage : pcst_pkg
`default_nettype wire

// ---- verilog/pcst_top.sv ----
// Purpose: Switch decode, self-test entry, print inhibit and paper paper_auto_insert
// Assumes: Inputs synchronous to clk; switch bits high when ON
// Notes: Wishbone classic slave, ack one cycle after request
// Notes on behaviour
// RULE_01 - Bank one bits 1-2 baud 19200/9600/4800/1200; bit 3 hardware or software flow
// RULE_02 - Bank one bit 4 buffer 4096 or 45 bytes; bit 5 odd or even parity
// RULE_03 - Bit 6 parity check or ignore; bit 7 seven or eight bits; bit 8 interface
// RULE_04 - Bank one exists only on serial units; parallel units read it as zero
// RULE_05 - Bank two bits 1-2 give mechanism width 2, 3 or 4 inch
// RULE_06 - Bank two bit 3 registration memory; bit 4 cut after each test print
// RULE_07 - Feed button held at power-on enters self-test; printing starts while held
// RULE_08 - Self-test prints tickets endlessly until power removal, host interface unused
// RULE_09 - Self-test line after checkerboard starts with width digit 2, 3 or 4
// RULE_10 - No printing at all while head-up lever signal is active; print_en is registered and drops one clock after head_up rises
// RULE_11 - Roll paper_auto_insert feeds programmed length once paper reaches the guide
// RULE_12 - Fanfold paper_auto_insert feeds until the next top-of-form mark is sensed
// RULE_13 - After initial load, feed button advances paper manually
// RULE_14 - Switch banks sampled once after reset and held until next reset
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module pcst_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Switch banks and strap
    input wire logic [7:0] serial_switch_bank,
    input wire logic [3:0] mechanism_switch_bank,
    input wire logic serial_unit,
    // Operator and sensors
    input wire logic feed_button,
    input wire logic head_up,
    input wire logic paper_in_guide,
    input wire logic top_of_form_mark,
    // Print engine handshake
    input wire logic print_req,
    output logic print_en,
    output logic feed_en,
    output logic cut_pulse,
    output logic self_test,
    output logic [7:0] width_char
);
    // Whole block state, registered in one place
    typedef struct packed {
        pcst_pkg::pcst_state_t state;
        logic [7:0] sw1;
        logic [3:0] sw2;
        logic loaded;
        logic self_test;
        logic roll_auto;
        logic fan_auto;
        logic [7:0] feed_len;
        logic [7:0] step_cnt;
        logic [15:0] div_cnt;
        logic paper_seen;
        logic print_en;
        logic feed_en;
        logic cut_pulse;
        logic [7:0] width_char;
        logic [31:0] dat;
        logic ack;
    } pcst_regs_t;

    pcst_regs_t cur_ff;
    pcst_regs_t nxt_cur;
    logic step_en;
    logic wb_req;

    // Decode of mechanism width in inches
    function automatic logic [2:0] mech_inches(input logic [1:0] bits);
        case (bits)
            2'b00: mech_inches = 3'h2;
            2'b10: mech_inches = 3'h3;
            2'b01: mech_inches = 3'h4;
            // Both switches on is unused, falls back to narrowest
            default: mech_inches = 3'h2;
        endcase
    endfunction : mech_inches

    // Decode of baud rate
    function automatic logic [15:0] baud_of(input logic [1:0] bits);
        case (bits)
            2'b00: baud_of = pcst_pkg::BAUD_19200;
            2'b01: baud_of = pcst_pkg::BAUD_9600;
            2'b10: baud_of = pcst_pkg::BAUD_4800;
            default: baud_of = pcst_pkg::BAUD_1200;
        endcase
    endfunction : baud_of

    // Feed step enable and bus request
    assign step_en = (cur_ff.div_cnt == 16'(pcst_pkg::FEED_STEP_CYC - 1));
    assign wb_req = wb_cyc_i && wb_stb_i && !cur_ff.ack;

    // Next state
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.cut_pulse = 1'b0;
        nxt_cur.ack = 1'b0;
        nxt_cur.div_cnt = step_en ? 16'h0000 : cur_ff.div_cnt + 16'h0001;
        case (cur_ff.state)
            pcst_pkg::PCST_SAMPLE:
            begin
                // RULE_14 sample banks once
                // Later switch moves are ignored until the next reset
                // RULE_04 parallel units read bank one as zero
                nxt_cur.sw1 = serial_unit ? serial_switch_bank : 8'h00;
                nxt_cur.sw2 = mechanism_switch_bank;
                // RULE_09 width digit
                nxt_cur.width_char = pcst_pkg::ASCII_ZERO
                    + {5'h00, mech_inches(mechanism_switch_bank[1:0])};
                // RULE_07 button held at power-on
                nxt_cur.self_test = feed_button;
                nxt_cur.step_cnt = 8'h00;
                nxt_cur.state = feed_button ? pcst_pkg::PCST_TEST_PRINT
                                            : pcst_pkg::PCST_IDLE;
            end
            pcst_pkg::PCST_TEST_PRINT:
            begin
                // RULE_08 ticket length counted in steps
                // Raised head stalls the ticket rather than losing it
                if (step_en && !head_up)
                begin
                    nxt_cur.step_cnt = cur_ff.step_cnt + 8'h01;
                    if (cur_ff.step_cnt == pcst_pkg::TEST_TICKET_STEPS)
                    begin
                        nxt_cur.state = pcst_pkg::PCST_TEST_CUT;
                    end
                end
            end
            pcst_pkg::PCST_TEST_CUT:
            begin
                // RULE_06 cut only when bank two bit 4 on
                nxt_cur.cut_pulse = cur_ff.sw2[3];
                nxt_cur.step_cnt = 8'h00;
                // RULE_08 repeat without stopping
                nxt_cur.state = pcst_pkg::PCST_TEST_PRINT;
            end
            pcst_pkg::PCST_IDLE:
            begin
                nxt_cur.step_cnt = 8'h00;
                // Rising paper edge only, so resting paper never refeeds
                // Fanfold wins when both paper_auto_insert bits are set
                if (paper_in_guide && !cur_ff.paper_seen && cur_ff.fan_auto)
                begin
                    nxt_cur.state = pcst_pkg::PCST_FAN_FEED;
                end
                else if (paper_in_guide && !cur_ff.paper_seen
                         && cur_ff.roll_auto)
                begin
                    nxt_cur.state = pcst_pkg::PCST_ROLL_FEED;
                end
                else if (feed_button && cur_ff.loaded)
                begin
                    nxt_cur.state = pcst_pkg::PCST_MANUAL_FEED;
                end
                if (paper_in_guide && !cur_ff.roll_auto && !cur_ff.fan_auto)
                begin
                    nxt_cur.loaded = 1'b1;
                end
            end
            pcst_pkg::PCST_ROLL_FEED:
            begin
                // RULE_11 feed programmed length
                if (step_en)
                begin
                    nxt_cur.step_cnt = cur_ff.step_cnt + 8'h01;
                end
                if (cur_ff.step_cnt >= cur_ff.feed_len)
                begin
                    nxt_cur.loaded = 1'b1;
                    nxt_cur.state = pcst_pkg::PCST_IDLE;
                end
            end
            pcst_pkg::PCST_FAN_FEED:
            begin
                // RULE_12 feed to next mark
                // No length limit: unmarked forms feed until reset
                if (top_of_form_mark)
                begin
                    nxt_cur.loaded = 1'b1;
                    nxt_cur.state = pcst_pkg::PCST_IDLE;
                end
            end
            pcst_pkg::PCST_MANUAL_FEED:
            begin
                // RULE_13 manual advance while held
                if (!feed_button)
                begin
                    nxt_cur.state = pcst_pkg::PCST_IDLE;
                end
            end
            default:
            begin
                nxt_cur.state = pcst_pkg::PCST_IDLE;
            end
        endcase
        nxt_cur.paper_seen = paper_in_guide;
        // Feed motor runs in the feed states and in PCST_TEST_PRINT with the head down
        nxt_cur.feed_en = (nxt_cur.state == pcst_pkg::PCST_ROLL_FEED)
            || (nxt_cur.state == pcst_pkg::PCST_FAN_FEED)
            || (nxt_cur.state == pcst_pkg::PCST_MANUAL_FEED)
            || (nxt_cur.state == pcst_pkg::PCST_TEST_PRINT && !head_up);
        // RULE_10 head-up inhibits print
        nxt_cur.print_en = !head_up && (print_req
            || nxt_cur.state == pcst_pkg::PCST_TEST_PRINT);
        // Register access
        // Ack lasts one cycle; writes to read-only offsets are dropped
        if (wb_req)
        begin
            nxt_cur.ack = 1'b1;
            nxt_cur.dat = 32'h0000_0000;
            if (wb_we_i && wb_adr_i == pcst_pkg::ADDR_CONTROL)
            begin
                if (wb_sel_i[0])
                begin
                    // RULE_11 roll paper_auto_insert enable
                    nxt_cur.roll_auto = wb_dat_i[pcst_pkg::CTL_ROLL_AUTO];
                    // RULE_12 fanfold paper_auto_insert enable
                    nxt_cur.fan_auto = wb_dat_i[pcst_pkg::CTL_FAN_AUTO];
                end
                if (wb_sel_i[1])
                begin
                    nxt_cur.feed_len = wb_dat_i[pcst_pkg::CTL_FEED_LEN_LSB+:8];
                end
            end
            else if (!wb_we_i)
            begin
                case (wb_adr_i)
                    pcst_pkg::ADDR_SERIAL_CFG:
                    begin
                        // RULE_01 baud and flow control
                        // RULE_02 buffer size and parity sense
                        // RULE_03 parity use and length; the interface bit reads from ADDR_MECH_CFG
                        // Baud top bit is always zero, cut to fit 32 bits
                        nxt_cur.dat = {15'(baud_of(cur_ff.sw1[1:0])),
                            cur_ff.sw1[2],
                            cur_ff.sw1[3] ? pcst_pkg::RXBUF_SMALL
                                          : pcst_pkg::RXBUF_LARGE,
                            cur_ff.sw1[4], cur_ff.sw1[5],
                            cur_ff.sw1[6]};
                    end
                    pcst_pkg::ADDR_MECH_CFG:
                    begin
                        // RULE_05 width, RULE_06 memory and cut
                        nxt_cur.dat = {21'h000000, cur_ff.sw2[3],
                            cur_ff.sw2[2], mech_inches(cur_ff.sw2[1:0]),
                            cur_ff.sw1[7], 5'h00};
                    end
                    pcst_pkg::ADDR_CONTROL:
                    begin
                        nxt_cur.dat = {16'h0000, cur_ff.feed_len, 6'h00,
                            cur_ff.fan_auto, cur_ff.roll_auto};
                    end
                    pcst_pkg::ADDR_STATUS:
                    begin
                        // Bit 7 spare, reads zero
                        nxt_cur.dat = {24'h000000, 1'b0, cur_ff.state,
                            cur_ff.loaded, cur_ff.self_test, head_up,
                            paper_in_guide};
                    end
                    default:
                    begin
                        nxt_cur.dat = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // State register
    // Feed length takes its package reset, all else clears
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_ff <= '{state: pcst_pkg::PCST_SAMPLE,
                feed_len: pcst_pkg::FEED_LEN_RST, default: '0};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs from flip-flops
    // Plain wires off the state register, no logic after the flops
    assign wb_dat_o = cur_ff.dat;
    assign wb_ack_o = cur_ff.ack;
    assign print_en = cur_ff.print_en;
    assign feed_en = cur_ff.feed_en;
    assign cut_pulse = cur_ff.cut_pulse;
    assign self_test = cur_ff.self_test;
    assign width_char = cur_ff.width_char;
endmodule : pcst_top
`default_nettype wire

// ---- bench/pcst_host.sv ----
// Purpose: Host model issuing Wishbone classic register cycles
// Assumes: Slave answers within 20 cycles
// Notes: ok returns low when no ack came
`timescale 1ns/100ps
`default_nettype none
module pcst_host (
    // Clock
    input wire logic clk,
    // Request to slave
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [3:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat,
    // Answer from slave
    input wire logic [31:0] rdat,
    input wire logic ack
);
    // Bus idle at time zero
    initial
    begin
        {cyc, stb, we, adr, sel, dat} = '0;
    end

    // One single cycle, held until ack is sampled
    task xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
              input logic [3:0] s, output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        ok = (ack === 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : xfer
endmodule : pcst_host
`default_nettype wire

// ---- bench/pcst_top_asserts.sv ----
// Purpose: Port checks of the configuration and self-test block
// Assumes: Switches sampled at first edge after reset
// Notes: Bound into pcst_top
`timescale 1ns/100ps
`default_nettype none
module pcst_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic [3:0] mechanism_switch_bank,
    input wire logic feed_button,
    input wire logic head_up,
    input wire logic print_en,
    input wire logic feed_en,
    input wire logic cut_pulse,
    input wire logic self_test,
    input wire logic [7:0] width_char,
    input wire logic wb_ack_o,
    input wire logic wb_we_i
);
    logic sampled_ff;
    logic fb_ff;
    logic [3:0] sw2_ff;
    logic [7:0] wexp;
    // Own copy of the straps at the sample edge
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            {sampled_ff, sw2_ff, fb_ff} <= '0;
        else if (!sampled_ff)
            {sampled_ff, sw2_ff, fb_ff} <= {1'b1, mechanism_switch_bank,
                                            feed_button};
    // Expected width digit
    assign wexp = sw2_ff[1:0] == 2'b01 ? 8'h34 :
                  sw2_ff[1:0] == 2'b10 ? 8'h33 : 8'h32;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_width; sampled_ff |-> width_char == wexp; endproperty
    a_width: assert property (p_width) else $error("bad width");
    property p_mode; sampled_ff |-> self_test == fb_ff; endproperty
    a_mode: assert property (p_mode) else $error("bad mode");
    property p_whold; sampled_ff |=> $stable(width_char); endproperty
    a_whold: assert property (p_whold) else $error("width moved");
    property p_thold; sampled_ff |=> $stable(self_test); endproperty
    a_thold: assert property (p_thold) else $error("test left");
    property p_head; head_up |=> !print_en; endproperty
    a_head: assert property (p_head) else $error("print head up");
    property p_head2; head_up [*2] |-> !print_en; endproperty
    a_head2: assert property (p_head2) else $error("print held");
    property p_cut; cut_pulse |-> sw2_ff[3] && self_test; endproperty
    a_cut: assert property (p_cut) else $error("cut not set");
    property p_cut1; cut_pulse |=> !cut_pulse; endproperty
    a_cut1: assert property (p_cut1) else $error("cut long");
    c_test: cover property (self_test && print_en);
    c_feed: cover property (feed_en);
    c_wr: cover property (wb_ack_o && wb_we_i);
endmodule : pcst_top_asserts

bind pcst_top pcst_top_asserts u_chk (.clk(clk), .rst_b(rst_b),
    .mechanism_switch_bank(mechanism_switch_bank),
    .feed_button(feed_button), .head_up(head_up), .print_en(print_en),
    .feed_en(feed_en), .cut_pulse(cut_pulse), .self_test(self_test),
    .width_char(width_char), .wb_ack_o(wb_ack_o), .wb_we_i(wb_we_i));
`default_nettype wire

// ---- bench/pcst_top_tb.sv ----
// Purpose: Register and operator tests of the configuration block
// Assumes: 40 MHz clock, reset held 6 cycles
// Notes: Each switch set needs its own reset
`timescale 1ns/100ps
`default_nettype none
module pcst_top_tb;
    logic clk, rst_b, cyc, stb, we, ack, su, fb, hu, pig, mark, preq;
    logic pen, fen, cut, st, ok;
    logic [3:0] adr, sel, sw2;
    logic [7:0] sw1, wch;
    logic [31:0] wdat, rdat, q;
    int miscompares, checks_done, n;

    pcst_top dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .serial_switch_bank(sw1),
        .mechanism_switch_bank(sw2), .serial_unit(su), .feed_button(fb),
        .head_up(hu), .paper_in_guide(pig), .top_of_form_mark(mark),
        .print_req(preq), .print_en(pen), .feed_en(fen), .cut_pulse(cut),
        .self_test(st), .width_char(wch));
    pcst_host u_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(wdat), .rdat(rdat), .ack(ack));

    // Clock, 25 ns period
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk

    task xf(input logic w, input logic [3:0] a, input logic [31:0] d);
        u_host.xfer(w, a, d, 4'h3, q, ok);
        if (!ok)
        begin
            miscompares++;
            report_and_stop;
        end
    endtask : xf

    task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        xf(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rd

    task boot(input logic [7:0] s1, input logic [3:0] s2, input logic u,
              input logic f);
        @(posedge clk);
        {sw1, sw2, su, fb, rst_b} <= {s1, s2, u, f, 1'b0};
        {hu, pig, mark, preq} <= 4'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : boot

    task wait_feed(input logic v, input int lim);
        n = 0;
        while (fen !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(fen), 32'(v));
        if (fen !== v)
            report_and_stop;
    endtask : wait_feed

    function automatic logic [2:0] inch(input logic [3:0] s);
        inch = s[1:0] == 2'b01 ? 3'h4 : s[1:0] == 2'b10 ? 3'h3 : 3'h2;
    endfunction : inch

    function automatic logic [31:0] r0(input logic [7:0] s);
        logic [15:0] b;
        b = s[1:0] == 2'b00 ? pcst_pkg::BAUD_19200 :
            s[1:0] == 2'b01 ? pcst_pkg::BAUD_9600 :
            s[1:0] == 2'b10 ? pcst_pkg::BAUD_4800 : pcst_pkg::BAUD_1200;
        r0 = {b[14:0], s[2], s[3] ? pcst_pkg::RXBUF_SMALL :
              pcst_pkg::RXBUF_LARGE, s[4], s[5], s[6]};
    endfunction : r0

    // Main sequence
    initial
    begin
        {rst_b, su, fb, hu, pig, mark, preq, sw1, sw2} = '0;
        miscompares = 0;
        checks_done = 0;
        for (int i = 0; i < 5; i++)
        begin
            boot(8'(8'h55 * i), 4'(4'h5 * i), i != 4, 1'b0);
            chk(32'(wch), 32'(pcst_pkg::ASCII_ZERO + inch(sw2)));
            sw1 <= ~sw1;
            sw2 <= ~sw2;
            xf(1'b1, pcst_pkg::ADDR_SERIAL_CFG, 32'hffff_ffff);
            rd(pcst_pkg::ADDR_SERIAL_CFG, '1, r0(i == 4 ? 8'h0 : ~sw1));
            rd(pcst_pkg::ADDR_MECH_CFG, '1, {21'h0, ~sw2[3:2], inch(~sw2),
               i == 4 ? 1'b0 : ~sw1[7], 5'h0});
            $display("switch set %0d done", i);
        end
        rd(4'h2, '1, 32'h0);
        xf(1'b1, pcst_pkg::ADDR_CONTROL, 32'h0000_0302);
        rd(pcst_pkg::ADDR_CONTROL, '1, 32'h0000_0302);
        pig <= 1'b1;
        wait_feed(1'b1, 50);
        repeat (5) @(posedge clk);
        mark <= 1'b1;
        wait_feed(1'b0, 20);
        mark <= 1'b0;
        rd(pcst_pkg::ADDR_STATUS, 32'h8, 32'h8);
        fb <= 1'b1;
        wait_feed(1'b1, 50);
        fb <= 1'b0;
        $display("fanfold and manual feed done");
        boot(8'h0, 4'h8, 1'b1, 1'b1);
        chk(32'(st), 32'h1);
        preq <= 1'b1;
        for (n = 0; pen !== 1'b1 && n < 20; n++)
            @(posedge clk);
        chk(32'(pen), 32'h1);
        hu <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(pen), 32'h0);
        $display("self test done");
        boot(8'h0, 4'h0, 1'b1, 1'b0);
        xf(1'b1, pcst_pkg::ADDR_CONTROL, 32'h0000_0101);
        pig <= 1'b1;
        wait_feed(1'b1, 50);
        wait_feed(1'b0, 41000);
        $display("roll paper_auto_insert done");
        report_and_stop;
    end
endmodule : pcst_top_tb
`default_nettype wire
